// ===== verilog/can_diag_pkg.sv
// Operation
// (RQ1) Sleep wake: regulator on, then host reset released
// (RQ2) Stop wake: interrupt pulse; bus wake sets flag
// (RQ3) Normal/standby sleep-wake: only the wake flag
// (RQ4) Host reads wake flag before low power
// (RQ5) Wake flag holds until transmit-receive mode command
// (RQ6) Ground comparator table decoded per driver phase
// (RQ7) Battery comparator table decoded per driver phase
// (RQ8) Supply comparator table decoded per driver phase
// (RQ9) Recessive only detects; dominant names the line
// (RQ10) Low line faults low register, high high
// (RQ11) Fault bit set; unidentified bit while unnamed
// (RQ12) Identified fault written, unidentified bit cleared
// (RQ13) Five same-fault cycles before identified
// (RQ14) Recessive detection alone raises both flags
// (RQ15) Sample receive pin at receiver rising edge
// (RQ16) Three faulty samples confirm receive stuck
// (RQ17) Stuck: latch error, driver off, flag set
// (RQ18) Driver off until cleared and re-enable written
// (RQ19) Three valid dominant pulses within window wake
// (RQ20) Capture comparators per phase, match phase table
package can_diag_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] CAN_STAT_OFS = 8'h04;
  localparam logic [7:0] LOW_FAULT_OFS = 8'h08;
  localparam logic [7:0] HIGH_FAULT_OFS = 8'h0C;

  // Control register fields
  localparam int SBC_MODE_LSB = 0;
  localparam int CAN_MODE_LSB = 2;
  localparam int REENABLE_BIT = 4;

  // CAN status fields
  localparam int WAKE_BIT = 0;
  localparam int UNIDENT_BIT = 1;
  localparam int FAULT_BIT = 2;
  localparam int DRV_OFF_BIT = 3;

  // Line fault register fields
  localparam int GND_BIT = 0;
  localparam int BAT_BIT = 1;
  localparam int SUP_BIT = 2;
  localparam int RX_STUCK_BIT = 3;

  // Chip operating modes
  typedef enum logic [1:0] {
    SBC_NORMAL = 2'h0,
    SBC_STANDBY = 2'h1,
    SBC_STOP = 2'h2,
    SBC_SLEEP = 2'h3
  } sbc_mode_t;

  // CAN interface modes
  typedef enum logic [1:0] {
    CAN_TRANSMIT_RECEIVE_MODE = 2'h0,
    CAN_SLEEP_WAKE = 2'h1,
    CAN_SLEEP_NOWAKE = 2'h2
  } can_mode_t;

  // Reset values
  localparam logic [1:0] SBC_MODE_RST = 2'h0;
  localparam logic [1:0] CAN_MODE_RST = 2'h0;
  localparam logic [10:0] PIN_SYNC_RST = 11'h2B0; // Idle pin levels, no fault

  // Timing
  localparam int CLK_HZ = 20_000_000;
  localparam int WAKE_MIN_NS = 500;
  localparam int WAKE_MAX_US = 500;
  localparam int WAKE_WIN_US = 1000;
  localparam int WAKE_MIN_CYC = (WAKE_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int WAKE_MAX_CYC = WAKE_MAX_US * (CLK_HZ / 1_000_000);
  localparam int WAKE_WIN_CYC = WAKE_WIN_US * (CLK_HZ / 1_000_000);

  // Counts
  localparam int WAKE_PULSES = 3;
  localparam int IDENT_CYCLES = 5;
  localparam int RX_SAMPLES = 3;

endpackage

// ===== verilog/fault_diag_if.sv
`timescale 1ns/1ps
// Comparator inputs and decoded fault results
interface fault_diag_if;
  logic [5:0] cmp; // {hg, lg, hb, lb, hs, ls} synchronised
  logic drv_dom; // Driver in dominant phase
  logic fault_seen; // Some fault present
  logic unident; // Fault present but not yet named
  logic [2:0] low_fault; // {sup, bat, gnd} on low line
  logic [2:0] high_fault; // {sup, bat, gnd} on high line
  logic ident_stb; // New identification result valid
  modport decoder (input cmp, input drv_dom, output fault_seen, output unident,
    output low_fault, output high_fault, output ident_stb);
  modport owner (output cmp, output drv_dom, input fault_seen, input unident,
    input low_fault, input high_fault, input ident_stb);
endinterface

// ===== verilog/wake_pattern_filter.sv
`timescale 1ns/1ps
// Pattern filter on the wake receiver: three good pulses in a window
module wake_pattern_filter #(
  parameter int MAX_CYC = can_diag_pkg::WAKE_MAX_CYC,
  parameter int WIN_CYC = can_diag_pkg::WAKE_WIN_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic dom,
  output logic wake_pulse
);
  localparam int CW = 16;
  logic [CW-1:0] width_ff; // Current pulse length
  logic [CW-1:0] gap_ff; // Time since last pulse
  logic [CW-1:0] win_ff; // Time since first pulse
  logic [1:0] count_ff; // Accepted pulses
  logic dom_d_ff; // Previous line level
  logic pulse_end;
  logic good;

  assign pulse_end = dom_d_ff && !dom;
  assign good = (width_ff > CW'(can_diag_pkg::WAKE_MIN_CYC)) && (width_ff < CW'(MAX_CYC));

  // Pulse counter; any bad pulse or timeout restarts the pattern
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      width_ff <= '0;
      gap_ff <= '0;
      win_ff <= '0;
      count_ff <= '0;
      dom_d_ff <= 1'b0;
      wake_pulse <= 1'b0;
    end else begin
      dom_d_ff <= dom;
      wake_pulse <= 1'b0;
      // Saturating counters avoid wrap in long idle
      if (dom && width_ff != '1) width_ff <= width_ff + 1'b1;
      if (!dom) width_ff <= '0;
      if (!dom && gap_ff != '1) gap_ff <= gap_ff + 1'b1;
      if (dom) gap_ff <= '0;
      if (count_ff != 2'h0 && win_ff != '1) win_ff <= win_ff + 1'b1;
      if (!enable) begin
        count_ff <= '0;
        win_ff <= '0;
      end else if (pulse_end) begin
        if (!good) begin
          count_ff <= '0; // RQ19
          win_ff <= '0;
        end else if (count_ff == 2'(can_diag_pkg::WAKE_PULSES - 1)) begin
          count_ff <= '0;
          win_ff <= '0;
          wake_pulse <= (win_ff < CW'(WIN_CYC)); // RQ19
        end else begin
          count_ff <= count_ff + 1'b1;
        end
      end else if (count_ff != 2'h0 && (gap_ff >= CW'(MAX_CYC) || win_ff >= CW'(WIN_CYC))) begin
        count_ff <= '0; // RQ19
        win_ff <= '0;
      end
    end
  end
endmodule // wake_pattern_filter

// ===== verilog/bus_fault_decoder.sv
`timescale 1ns/1ps
// Per-phase comparator capture and fault identification
module bus_fault_decoder (
  input wire logic pclk,
  input wire logic presetn,
  fault_diag_if.decoder fd
);
  logic [5:0] rec_ff; // Last recessive capture
  logic [5:0] dom_ff; // Last dominant capture
  logic dom_d_ff; // Previous driver phase
  logic [5:0] code_ff; // Fault named in last cycle
  logic [2:0] same_ff; // Consecutive equal cycles
  logic have_dom_ff; // A dominant capture exists
  logic [5:0] code_now;
  logic rec_bad;

  // Recessive table: ground 11, battery 00, supply 00
  assign rec_bad = (rec_ff[5:4] != 2'h3) || (rec_ff[3:2] != 2'h0) || (rec_ff[1:0] != 2'h0); // RQ9

  // Decode one comparator pair against both phase tables
  function automatic logic [1:0] name_pair(input logic [1:0] r, input logic [1:0] d,
                                           input logic gnd);
    name_pair = 2'h0; // {high, low}
    if (gnd) begin
      if (r == 2'h0 && d == 2'h2) name_pair = 2'h1; // RQ6
      if (r == 2'h0 && d == 2'h0) name_pair = 2'h2; // RQ6
    end else begin
      if (r == 2'h3 && d == 2'h3) name_pair = 2'h1; // RQ7 RQ8
      if (r == 2'h3 && d == 2'h2) name_pair = 2'h2; // RQ7 RQ8
    end
  endfunction

  // Code layout {hsup, hbat, hgnd, lsup, lbat, lgnd}
  always_comb begin
    logic [1:0] g;
    logic [1:0] b;
    logic [1:0] s;
    g = name_pair(rec_ff[5:4], dom_ff[5:4], 1'b1); // RQ20
    b = name_pair(rec_ff[3:2], dom_ff[3:2], 1'b0);
    s = name_pair(rec_ff[1:0], dom_ff[1:0], 1'b0);
    code_now = {s[1], b[1], g[1], s[0], b[0], g[0]};
  end

  // Phase capture, separate for each driver state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rec_ff <= 6'h30;
      dom_ff <= 6'h00;
      dom_d_ff <= 1'b0;
      have_dom_ff <= 1'b0;
    end else begin
      dom_d_ff <= fd.drv_dom;
      if (fd.drv_dom) begin
        dom_ff <= fd.cmp; // RQ20
        have_dom_ff <= 1'b1;
      end else begin
        rec_ff <= fd.cmp; // RQ20
      end
    end
  end

  // Cycle evaluation at each dominant-to-recessive end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_ff <= '0;
      same_ff <= '0;
      fd.ident_stb <= 1'b0;
      fd.low_fault <= '0;
      fd.high_fault <= '0;
    end else begin
      fd.ident_stb <= 1'b0;
      if (dom_d_ff && !fd.drv_dom && have_dom_ff) begin // RQ13
        code_ff <= code_now;
        if (code_now == 6'h00) begin
          same_ff <= '0;
          fd.ident_stb <= 1'b1;
          fd.low_fault <= '0;
          fd.high_fault <= '0;
        end else if (code_now != code_ff) begin
          same_ff <= 3'h1; // RQ13
        end else if (same_ff < 3'(can_diag_pkg::IDENT_CYCLES)) begin
          same_ff <= same_ff + 1'b1;
          if (same_ff == 3'(can_diag_pkg::IDENT_CYCLES - 1)) begin
            fd.ident_stb <= 1'b1; // RQ12
            fd.low_fault <= code_now[2:0]; // RQ10
            fd.high_fault <= code_now[5:3]; // RQ10
          end
        end
      end
    end
  end

  // Flags: recessive evidence alone warns the host
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fd.fault_seen <= 1'b0;
      fd.unident <= 1'b0;
    end else begin
      fd.fault_seen <= rec_bad || (code_ff != 6'h00); // RQ11 RQ14
      fd.unident <= (rec_bad || code_ff != 6'h00) &&
                    (same_ff < 3'(can_diag_pkg::IDENT_CYCLES)); // RQ11 RQ12 RQ14
    end
  end
endmodule // bus_fault_decoder

// ===== verilog/can_wake_diag.sv
`timescale 1ns/1ps
// CAN wake reporting and bus fault diagnosis with APB registers
module can_wake_diag #(
  parameter int WAKE_MAX_CYC = can_diag_pkg::WAKE_MAX_CYC,
  parameter int WAKE_WIN_CYC = can_diag_pkg::WAKE_WIN_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic low_line_ground_cmp,
  input wire logic high_line_ground_cmp,
  input wire logic low_line_battery_cmp,
  input wire logic high_line_battery_cmp,
  input wire logic low_line_supply_cmp,
  input wire logic high_line_supply_cmp,
  input wire logic tx_dom_pin,
  input wire logic diff_rx,
  input wire logic wake_rx,
  input wire logic rx_pin_sense,
  input wire logic other_wake,
  output logic int_pulse,
  output logic regulator_on,
  output logic host_rst_n,
  output logic driver_enable,
  output logic rx_out
);
  // Synchroniser stages: first stage read only by second
  logic [10:0] sync1_ff;
  logic [10:0] sync2_ff;
  logic [5:0] cmp_s;
  logic drv_dom_s;
  logic diff_s;
  logic wake_s;
  logic rxs_s;
  logic other_s;

  // Register state
  logic [1:0] sbc_mode_ff; // Chip operating mode
  logic [1:0] can_mode_ff; // CAN interface mode
  logic bus_wake_flag_ff; // Sticky bus wake event
  logic [2:0] low_line_fault_reg_ff; // Identified low line faults
  logic [3:0] high_line_fault_reg_ff; // High line faults plus stuck flag
  logic receive_stuck_flag_ff; // Latched receive stuck error
  logic [1:0] rx_bad_cnt_ff; // Faulty receive samples
  logic rx_ok_ff; // Last sample was healthy
  logic diff_d_ff; // Previous receiver level
  logic reg_on_d_ff; // Regulator state one cycle ago

  // Bus decode
  logic acc; // Access phase taken this edge
  logic wr;
  logic mapped;
  logic reenable_wr;
  logic mode_wr;
  logic bus_wake;
  logic wake_any;
  logic [1:0] nxt_can_mode;

  fault_diag_if fdi ();

  // Two-flop sync of every pin
  // Reset to idle levels, so no false receiver edge or fault follows reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= can_diag_pkg::PIN_SYNC_RST;
      sync2_ff <= can_diag_pkg::PIN_SYNC_RST;
    end else begin
      sync1_ff <= {other_wake, rx_pin_sense, wake_rx, diff_rx, tx_dom_pin,
                   high_line_ground_cmp, low_line_ground_cmp,
                   high_line_battery_cmp, low_line_battery_cmp,
                   high_line_supply_cmp, low_line_supply_cmp};
      sync2_ff <= sync1_ff;
    end
  end

  assign cmp_s = sync2_ff[5:0];
  assign drv_dom_s = sync2_ff[6] && driver_enable;
  assign diff_s = sync2_ff[7];
  assign wake_s = sync2_ff[8];
  assign rxs_s = sync2_ff[9];
  assign other_s = sync2_ff[10];

  assign fdi.cmp = cmp_s;
  assign fdi.drv_dom = drv_dom_s;

  bus_fault_decoder u_dec (
    .pclk(pclk),
    .presetn(presetn),
    .fd(fdi.decoder)
  );

  wake_pattern_filter #(
    .MAX_CYC(WAKE_MAX_CYC),
    .WIN_CYC(WAKE_WIN_CYC)
  ) u_wake (
    .pclk(pclk),
    .presetn(presetn),
    .enable(can_mode_ff == can_diag_pkg::CAN_SLEEP_WAKE),
    .dom(wake_s),
    .wake_pulse(bus_wake)
  );

  // Address decode; answer one cycle into the access phase
  assign acc = psel && penable && pready;
  assign wr = acc && pwrite;
  assign mapped = (paddr == can_diag_pkg::CTRL_OFS) || (paddr == can_diag_pkg::CAN_STAT_OFS) ||
                  (paddr == can_diag_pkg::LOW_FAULT_OFS) || (paddr == can_diag_pkg::HIGH_FAULT_OFS);
  assign mode_wr = wr && (paddr == can_diag_pkg::CTRL_OFS);
  assign reenable_wr = mode_wr && pwdata[can_diag_pkg::REENABLE_BIT];
  assign nxt_can_mode = pwdata[can_diag_pkg::CAN_MODE_LSB +: 2];
  assign wake_any = bus_wake || other_s;

  // Ready and error, both registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
    end
  end

  // Read data captured as ready rises
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && penable && !pready && !pwrite) begin
      case (paddr)
        can_diag_pkg::CTRL_OFS: prdata <= {28'h0000000, can_mode_ff, sbc_mode_ff};
        can_diag_pkg::CAN_STAT_OFS: prdata <= {28'h0000000, !driver_enable, fdi.fault_seen,
                                               fdi.unident, bus_wake_flag_ff}; // RQ11
        can_diag_pkg::LOW_FAULT_OFS: prdata <= {29'h0, low_line_fault_reg_ff};
        can_diag_pkg::HIGH_FAULT_OFS: prdata <= {28'h0000000, high_line_fault_reg_ff};
        default: prdata <= '0;
      endcase
    end
  end

  // Modes; a wake from sleep returns the chip to normal
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sbc_mode_ff <= can_diag_pkg::SBC_MODE_RST;
      can_mode_ff <= can_diag_pkg::CAN_MODE_RST;
    end else begin
      if (mode_wr) begin
        sbc_mode_ff <= pwdata[can_diag_pkg::SBC_MODE_LSB +: 2];
        // Unused code 3 falls back to sleep without wake
        can_mode_ff <= (nxt_can_mode == 2'h3) ? 2'(can_diag_pkg::CAN_SLEEP_NOWAKE) : nxt_can_mode;
      end
      if (wake_any && (sbc_mode_ff == can_diag_pkg::SBC_SLEEP ||
                       sbc_mode_ff == can_diag_pkg::SBC_STOP)) begin
        sbc_mode_ff <= can_diag_pkg::SBC_NORMAL; // RQ1
      end
    end
  end

  // Regulator on first, host reset released two cycles later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      regulator_on <= 1'b1;
      reg_on_d_ff <= 1'b1;
      host_rst_n <= 1'b0;
    end else begin
      regulator_on <= (sbc_mode_ff != can_diag_pkg::SBC_SLEEP); // RQ1
      reg_on_d_ff <= regulator_on;
      host_rst_n <= regulator_on && reg_on_d_ff; // RQ1
    end
  end

  // Interrupt pulse only for wakes out of stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_pulse <= 1'b0;
    end else begin
      int_pulse <= wake_any && (sbc_mode_ff == can_diag_pkg::SBC_STOP); // RQ2
    end
  end

  // Wake flag; a new wake beats the clearing command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_wake_flag_ff <= 1'b0;
    end else if (bus_wake) begin
      bus_wake_flag_ff <= 1'b1; // RQ2 RQ3
    end else if (mode_wr && nxt_can_mode == can_diag_pkg::CAN_TRANSMIT_RECEIVE_MODE) begin
      bus_wake_flag_ff <= 1'b0; // RQ5
    end
  end

  // Line registers follow each identification result
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_line_fault_reg_ff <= '0;
      high_line_fault_reg_ff <= '0;
    end else begin
      if (fdi.ident_stb) begin
        low_line_fault_reg_ff <= fdi.low_fault; // RQ10 RQ12
        high_line_fault_reg_ff[2:0] <= fdi.high_fault; // RQ10 RQ12
      end
      high_line_fault_reg_ff[can_diag_pkg::RX_STUCK_BIT] <= receive_stuck_flag_ff; // RQ17
    end
  end

  // Receive pin check at each receiver low-to-high edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      diff_d_ff <= 1'b1;
      rx_bad_cnt_ff <= '0;
      rx_ok_ff <= 1'b1;
    end else begin
      diff_d_ff <= diff_s;
      if (diff_s && !diff_d_ff) begin // RQ15
        rx_ok_ff <= !rxs_s;
        if (!rxs_s) begin
          rx_bad_cnt_ff <= '0;
        end else if (rx_bad_cnt_ff < 2'(can_diag_pkg::RX_SAMPLES)) begin
          rx_bad_cnt_ff <= rx_bad_cnt_ff + 1'b1; // RQ16
        end
      end
    end
  end

  // Stuck error latch; released only by host after recovery
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      receive_stuck_flag_ff <= 1'b0;
    end else if (rx_bad_cnt_ff == 2'(can_diag_pkg::RX_SAMPLES)) begin
      receive_stuck_flag_ff <= 1'b1; // RQ16 RQ17
    end else if (reenable_wr && rx_ok_ff) begin
      receive_stuck_flag_ff <= 1'b0; // RQ18
    end
  end

  // Driver follows the error latch and the CAN mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      driver_enable <= 1'b1;
      rx_out <= 1'b1;
    end else begin
      driver_enable <= !receive_stuck_flag_ff && !(rx_bad_cnt_ff == 2'(can_diag_pkg::RX_SAMPLES))
                       && (can_mode_ff == can_diag_pkg::CAN_TRANSMIT_RECEIVE_MODE); // RQ17 RQ18
      rx_out <= diff_s || (can_mode_ff != can_diag_pkg::CAN_TRANSMIT_RECEIVE_MODE);
    end
  end

endmodule // can_wake_diag

// ===== test/can_wake_diag_properties.sv
`timescale 1ns/1ps
// Port checks for wake reporting, receive stuck and register access
module can_wake_diag_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic diff_rx,
  input wire logic int_pulse,
  input wire logic regulator_on,
  input wire logic host_rst_n,
  input wire logic driver_enable,
  input wire logic rx_out
);
  // Single domain, so clock and reset are given once
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_INT_ONE_CYCLE: assert property (int_pulse |=> !int_pulse)
    else $error("interrupt pulse longer than one cycle");
  AST_INT_HOST_AWAKE: assert property (int_pulse |-> regulator_on && host_rst_n)
    else $error("interrupt pulse while host supply is off");
  AST_HOST_AFTER_REG: assert property ($rose(host_rst_n) |-> regulator_on && $past(regulator_on))
    else $error("host reset released before regulator");
  // Driver may only come back through a register write
  AST_DRV_REENABLE: assert property ($rose(driver_enable) |->
    $past(psel && pwrite, 1) || $past(psel && pwrite, 2) || $past(psel && pwrite, 3))
    else $error("driver enabled without a write");
  AST_RX_OUT_FOLLOWS: assert property ($fell(rx_out) |->
    !$past(diff_rx, 2) || !$past(diff_rx, 3) || !$past(diff_rx, 4))
    else $error("receive output fell without receiver low");
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_PREADY_CAUSE: assert property (pready |-> $past(psel && penable))
    else $error("pready without access phase");
  AST_PREADY_BOUND: assert property (psel && penable |-> ##[0:2] pready)
    else $error("access phase not answered");
  AST_ERR_ZERO: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error response with data or without pready");
endmodule // can_wake_diag_properties

// ===== test/can_bus_model.sv
`timescale 1ns/1ps
// Bus lines, comparators and host receive pin as seen by the block
module can_bus_model (
  input wire logic pclk,
  input wire logic tx_dom,
  input wire logic [2:0] fault,
  input wire logic stuck,
  input wire logic rx_out,
  output logic [5:0] cmp,
  output logic diff_rx,
  output logic rx_pin_sense,
  output logic wake_rx
);
  // Fault codes: 0 none, odd low line, even high line; ground, battery, supply
  function automatic logic [1:0] pair(input logic [2:0] f, input logic [2:0] lo, input logic d);
    if (f == lo)
      return 2'h3;
    if (f == lo + 3'h1)
      return d ? 2'h2 : 2'h3;
    return 2'h0;
  endfunction

  // Ground pair {high, low}: both low on a recessive short
  assign cmp[5:4] = tx_dom ? ((fault == 3'h2) ? 2'h0 : 2'h2)
                           : ((fault == 3'h1 || fault == 3'h2) ? 2'h0 : 2'h3);
  assign cmp[3:2] = pair(fault, 3'h3, tx_dom);
  assign cmp[1:0] = pair(fault, 3'h5, tx_dom);
  // Receiver low while dominant
  assign diff_rx = !tx_dom;
  // A short to the logic supply holds the pin high
  assign rx_pin_sense = stuck | rx_out;

  // Three dominant pulses, width and gap of w cycles
  task automatic send_wake(input int w);
    repeat (3) begin
      wake_rx <= 1'b1;
      repeat (w) @(posedge pclk);
      wake_rx <= 1'b0;
      repeat (w) @(posedge pclk);
    end
  endtask

  initial wake_rx = 1'b0;
endmodule // can_bus_model

// ===== test/can_wake_diag_tb_top.sv
`timescale 1ns/1ps
`define check(got, exp) begin samples_checked++; if ((got) !== (exp)) begin bad_count++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); end end
module can_wake_diag_tb_top;
  localparam logic [7:0] CTRL = can_diag_pkg::CTRL_OFS;
  localparam logic [7:0] STAT = can_diag_pkg::CAN_STAT_OFS;
  localparam logic [7:0] LOWR = can_diag_pkg::LOW_FAULT_OFS;
  localparam logic [7:0] HIGHR = can_diag_pkg::HIGH_FAULT_OFS;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, int_pulse, regulator_on;
  logic host_rst_n, driver_enable, rx_out, tx_dom, diff_rx, wake_rx, rx_pin_sense, stuck, e, oth;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q, d;
  logic [5:0] cmp;
  logic [2:0] fault;
  int bad_count, samples_checked, cycles, ints, w;

  can_wake_diag #(.WAKE_MAX_CYC(100), .WAKE_WIN_CYC(200)) can_wake_diag_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .high_line_ground_cmp(cmp[5]), .low_line_ground_cmp(cmp[4]),
    .high_line_battery_cmp(cmp[3]), .low_line_battery_cmp(cmp[2]),
    .high_line_supply_cmp(cmp[1]), .low_line_supply_cmp(cmp[0]),
    .tx_dom_pin(tx_dom), .diff_rx(diff_rx), .wake_rx(wake_rx), .rx_pin_sense(rx_pin_sense),
    .other_wake(oth), .int_pulse(int_pulse), .regulator_on(regulator_on),
    .host_rst_n(host_rst_n), .driver_enable(driver_enable), .rx_out(rx_out));

  can_bus_model can_bus_model_inst (.pclk(pclk), .tx_dom(tx_dom), .fault(fault),
    .stuck(stuck), .rx_out(rx_out), .cmp(cmp), .diff_rx(diff_rx),
    .rx_pin_sense(rx_pin_sense), .wake_rx(wake_rx));

  // Clock, interrupt count and hang guard
  always #25 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles++;
    if (int_pulse === 1'b1)
      ints++;
    if (cycles == 20000) begin
      bad_count++;
      results();
    end
  end

  // One APB transfer; held until pready is sampled high
  task automatic apb(input logic [7:0] a, input logic wr, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Dominant then recessive driver phase, n times
  task automatic bus_cycles(input int n);
    repeat (n) begin
      tx_dom <= 1'b1;
      repeat (6) @(posedge pclk);
      tx_dom <= 1'b0;
      repeat (6) @(posedge pclk);
    end
  endtask

  function automatic logic [31:0] exp_line(input int f, input int hi);
    if (f == 0 || (f - 1) % 2 != hi)
      return 32'h0;
    return 32'h1 << ((f - 1) / 2);
  endfunction

  task automatic results();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    {pclk, presetn, psel, penable, pwrite, tx_dom, stuck, oth} = 8'h0;
    {paddr, pwdata, fault} = 43'h0;
    void'($urandom(32'h2377));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Register reset values, random mode readback, unmapped place
    for (int i = 0; i < 4; i++) begin
      apb((i == 0) ? CTRL : (i == 1) ? STAT : (i == 2) ? LOWR : HIGHR, 1'b0, 32'h0);
      `check(q, 32'h0)
    end
    repeat (6) begin
      d = $urandom & 32'hFFFF_FFED;
      apb(CTRL, 1'b1, d);
      apb(CTRL, 1'b0, 32'h0);
      `check(q, {28'h0, (d[3:2] == 2'h3) ? 2'h2 : d[3:2], d[1:0]})
    end
    apb(8'h10, 1'b0, 32'h0);
    `check({e, q}, 33'h1_0000_0000)
    $display("test registers done");
    // Wake in each chip mode with bus wake enabled
    for (int m = 0; m < 4; m++) begin
      ints = 0;
      apb(CTRL, 1'b1, {28'h0, 2'h1, 2'(m)});
      repeat (4) @(posedge pclk);
      `check(regulator_on, logic'(m != 3))
      w = $urandom_range(45, 12);
      can_bus_model_inst.send_wake(w);
      for (int n = 0; n < 60 && host_rst_n !== 1'b1; n++)
        @(posedge pclk);
      `check(regulator_on, 1'b1)
      `check(ints, int'(m == 2))
      apb(STAT, 1'b0, 32'h0);
      `check(q[can_diag_pkg::WAKE_BIT], 1'b1)
      apb(STAT, 1'b0, 32'h0);
      `check(q[can_diag_pkg::WAKE_BIT], 1'b1)
      apb(CTRL, 1'b1, 32'h0);
      apb(STAT, 1'b0, 32'h0);
      `check(q[can_diag_pkg::WAKE_BIT], 1'b0)
    end
    // Non-bus wake out of stop: interrupt only, bus wake flag untouched
    ints = 0;
    apb(CTRL, 1'b1, 32'h2);
    oth <= 1'b1;
    repeat (2) @(posedge pclk);
    oth <= 1'b0;
    repeat (6) @(posedge pclk);
    `check(ints, 1)
    apb(STAT, 1'b0, 32'h0);
    `check(q[can_diag_pkg::WAKE_BIT], 1'b0)
    $display("test wake done");
    // Each bus fault: idle warning, boundary count, identification
    for (int f = 1; f < 7; f++) begin
      fault <= 3'(f);
      repeat (8) @(posedge pclk);
      apb(STAT, 1'b0, 32'h0);
      `check(q[2:1], 2'h3)
      bus_cycles(4);
      apb(STAT, 1'b0, 32'h0);
      `check(q[2:1], 2'h3)
      bus_cycles(1);
      apb(STAT, 1'b0, 32'h0);
      `check(q[2:1], 2'h2)
      apb(LOWR, 1'b0, 32'h0);
      `check(q, exp_line(f, 0))
      apb(HIGHR, 1'b0, 32'h0);
      `check(q, exp_line(f, 1))
      fault <= 3'h0;
      bus_cycles(2);
      apb(LOWR, 1'b0, 32'h0);
      `check(q, 32'h0)
    end
    $display("test faults done");
    // Receive pin stuck high: two samples, third, blocked and real recovery
    stuck <= 1'b1;
    bus_cycles(2);
    `check(driver_enable, 1'b1)
    bus_cycles(1);
    `check(driver_enable, 1'b0)
    apb(HIGHR, 1'b0, 32'h0);
    `check(q[can_diag_pkg::RX_STUCK_BIT], 1'b1)
    apb(CTRL, 1'b1, 32'h10);
    repeat (4) @(posedge pclk);
    `check(driver_enable, 1'b0)
    stuck <= 1'b0;
    bus_cycles(1);
    apb(CTRL, 1'b1, 32'h10);
    repeat (4) @(posedge pclk);
    `check(driver_enable, 1'b1)
    $display("test receive stuck done");
    results();
  end
endmodule // can_wake_diag_tb_top

bind can_wake_diag can_wake_diag_properties can_wake_diag_properties_inst (.pclk, .presetn,
  .psel, .penable, .pwrite, .prdata, .pready, .pslverr, .diff_rx, .int_pulse, .regulator_on,
  .host_rst_n, .driver_enable, .rx_out);
